// ### rtl/wdg_pkg.sv
// Purpose: shared constants and types of the watchdog block
// Assumes: core clock of 10 MHz
// Notes:   timing figures kept in their own units, cycle counts derived
package wdg_pkg;
    localparam int CNT_W               = 16;
    localparam int PSC_W               = 14;
    localparam int DIV_SLOW            = 16384;
    localparam int DIV_FAST            = 256;
    localparam int CLK_PERIOD_NS       = 100;
    localparam int DEFAULT_INTERVAL_NS = 6_500_000;
    localparam int DEFAULT_CYCLES      = DEFAULT_INTERVAL_NS / CLK_PERIOD_NS;
    // nearest whole number of fast ticks to the default interval
    localparam int DEFAULT_TICKS       = (DEFAULT_CYCLES + DIV_FAST / 2) / DIV_FAST;
    localparam int CNT_SPAN            = 65536;
    localparam logic [CNT_W-1:0] DEFAULT_RELOAD = CNT_W'(CNT_SPAN - DEFAULT_TICKS);
    localparam logic [CNT_W-1:0] CNT_MAX        = 16'hffff;
    localparam logic             DEFAULT_FAST   = 1'b1;
    localparam int PREWARN_CYCLES      = 16;
    localparam int WAIT_W              = 8;

    typedef enum logic [3:0] {
        ST_RUN    = 4'h1,
        ST_OFF    = 4'h2,
        ST_WARN   = 4'h4,
        ST_RSTREQ = 4'h8
    } wdg_state_t;
endpackage

// ### rtl/wdg_prescaler.sv
// Purpose: clock divider ahead of the watchdog counter
// Assumes: i_clear held while the counter is stopped
// Notes:   tick is combinational from the divider flops, one cycle wide
`timescale 1ns/1ps
module wdg_prescaler #(
    parameter int DIV_SLOW = wdg_pkg::DIV_SLOW,
    parameter int DIV_FAST = wdg_pkg::DIV_FAST
) (
    input  wire logic i_core_clk,
    input  wire logic i_reset,
    input  wire logic i_clear,
    input  wire logic i_sel_fast,
    output logic      o_tick
);
    localparam logic [wdg_pkg::PSC_W-1:0] LIM_SLOW = wdg_pkg::PSC_W'(DIV_SLOW - 1);
    localparam logic [wdg_pkg::PSC_W-1:0] LIM_FAST = wdg_pkg::PSC_W'(DIV_FAST - 1);

    logic [wdg_pkg::PSC_W-1:0] div_q;
    logic [wdg_pkg::PSC_W-1:0] div_d;
    logic [wdg_pkg::PSC_W-1:0] lim;

    always_comb
    begin
        lim    = i_sel_fast ? LIM_FAST : LIM_SLOW;
        o_tick = !i_clear && (div_q == lim);
        if (i_clear || o_tick)
        begin
            div_d = '0;
        end
        else
        begin
            div_d = div_q + 1'b1;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            div_q <= '0;
        end
        else
        begin
            div_q <= div_d;
        end
    end
endmodule

// ### rtl/wdg_timer.sv
// Purpose: watchdog counter with prewarning and reset request
// Assumes: commands and service are one-cycle pulses on the core clock
// Notes:   i_reset is the application reset; the reset request holds until it
`timescale 1ns/1ps
module wdg_timer #(
    parameter int PREWARN_CYCLES = wdg_pkg::PREWARN_CYCLES
) (
    input  wire logic                      i_core_clk,
    input  wire logic                      i_reset,
    input  wire logic                      i_service,
    input  wire logic                      i_guard_disable_command,
    input  wire logic                      i_guard_enable_command,
    input  wire logic                      i_cfg_load,
    input  wire logic [wdg_pkg::CNT_W-1:0] i_reload_value_setting,
    input  wire logic                      i_prescale_fast,
    output logic                           o_enabled,
    output logic [wdg_pkg::CNT_W-1:0]      o_count,
    output logic                           o_prewarn_irq,
    output logic                           o_reset_req
);
    localparam logic [wdg_pkg::WAIT_W-1:0] WAIT_LAST = wdg_pkg::WAIT_W'(PREWARN_CYCLES - 1);

    wdg_pkg::wdg_state_t          state_q;
    wdg_pkg::wdg_state_t          state_d;
    logic [wdg_pkg::CNT_W-1:0]    count_q;
    logic [wdg_pkg::CNT_W-1:0]    count_d;
    logic [wdg_pkg::CNT_W-1:0]    reload_q;
    logic [wdg_pkg::CNT_W-1:0]    reload_d;
    logic                         fast_q;
    logic                         fast_d;
    logic [wdg_pkg::WAIT_W-1:0]   wait_q;
    logic [wdg_pkg::WAIT_W-1:0]   wait_d;
    logic                         enabled_q;
    logic                         enabled_d;
    logic                         prewarn_q;
    logic                         prewarn_d;
    logic                         rstreq_q;
    logic                         rstreq_d;
    logic                         running;
    logic                         tick;
    logic                         psc_clear;
    logic                         overflow;

    assign running   = (state_q == wdg_pkg::ST_RUN);
    // prescaler frozen at zero whenever the counter is not running
    assign psc_clear = !running || i_service || i_cfg_load;

    wdg_prescaler #(
        .DIV_SLOW (wdg_pkg::DIV_SLOW),
        .DIV_FAST (wdg_pkg::DIV_FAST)
    ) u_prescaler (
        .i_core_clk (i_core_clk),
        .i_reset    (i_reset),
        .i_clear    (psc_clear),
        .i_sel_fast (fast_q),
        .o_tick     (tick)
    );

    // configuration; defaults only return on reset
    always_comb
    begin
        reload_d = reload_q;
        fast_d   = fast_q;
        if (i_cfg_load)
        begin
            reload_d = i_reload_value_setting;
            fast_d   = i_prescale_fast;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            reload_q <= wdg_pkg::DEFAULT_RELOAD;
            fast_q   <= wdg_pkg::DEFAULT_FAST;
        end
        else
        begin
            reload_q <= reload_d;
            fast_q   <= fast_d;
        end
    end

    // counter and supervision state
    always_comb
    begin
        state_d  = state_q;
        count_d  = count_q;
        wait_d   = '0;
        overflow = running && tick && !i_service && (count_q == wdg_pkg::CNT_MAX);
        case (state_q)
            wdg_pkg::ST_RUN:
            begin
                if (i_service)
                begin
                    count_d = reload_q;
                end
                else if (tick)
                begin
                    count_d = count_q + 1'b1;
                end
                if (i_guard_disable_command)
                begin
                    state_d = wdg_pkg::ST_OFF;
                end
                else if (overflow)
                begin
                    state_d = wdg_pkg::ST_WARN;
                end
            end
            wdg_pkg::ST_OFF:
            begin
                if (i_service)
                begin
                    count_d = reload_q;
                end
                if (i_guard_enable_command && !i_guard_disable_command)
                begin
                    state_d = wdg_pkg::ST_RUN;
                end
            end
            wdg_pkg::ST_WARN:
            begin
                // once warned, neither service nor disable can cancel the failure
                wait_d = wait_q + 1'b1;
                if (wait_q == WAIT_LAST)
                begin
                    state_d = wdg_pkg::ST_RSTREQ;
                end
            end
            wdg_pkg::ST_RSTREQ:
            begin
                state_d = wdg_pkg::ST_RSTREQ;
            end
            default:
            begin
                state_d = wdg_pkg::ST_RUN;
            end
        endcase
        enabled_d = (state_d == wdg_pkg::ST_RUN);
        prewarn_d = overflow && !i_guard_disable_command;
        rstreq_d  = (state_d == wdg_pkg::ST_RSTREQ);
    end

    always_ff @(posedge i_core_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            state_q   <= wdg_pkg::ST_RUN;
            count_q   <= wdg_pkg::DEFAULT_RELOAD;
            wait_q    <= '0;
            enabled_q <= 1'b1;
            prewarn_q <= 1'b0;
            rstreq_q  <= 1'b0;
        end
        else
        begin
            state_q   <= state_d;
            count_q   <= count_d;
            wait_q    <= wait_d;
            enabled_q <= enabled_d;
            prewarn_q <= prewarn_d;
            rstreq_q  <= rstreq_d;
        end
    end

    assign o_enabled     = enabled_q;
    assign o_count       = count_q;
    assign o_prewarn_irq = prewarn_q;
    assign o_reset_req   = rstreq_q;

    // helper logic read only by the assertions
    localparam int AST_PW = PREWARN_CYCLES;
    logic                       first_q;
    logic                       first_d;
    logic [wdg_pkg::PSC_W:0]    gap_q;
    logic [wdg_pkg::PSC_W:0]    gap_d;
    logic                       warned_q;
    logic                       warned_d;

    // gap follows the divider on its own so the tick spacing is checked independently
    always_comb
    begin
        first_d  = 1'b0;
        gap_d    = (psc_clear || tick) ? '0 : gap_q + 1'b1;
        warned_d = warned_q || prewarn_q;
    end

    always_ff @(posedge i_core_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            first_q  <= 1'b1;
            gap_q    <= '0;
            warned_q <= 1'b0;
        end
        else
        begin
            first_q  <= first_d;
            gap_q    <= gap_d;
            warned_q <= warned_d;
        end
    end

    AST_RESET_ENABLED: assert property (@(posedge i_core_clk) disable iff (i_reset)
        first_q |-> (o_enabled && running))
        else $error("watchdog not enabled after reset");

    // a tick in the disable cycle still lands; after that only a service moves the count
    AST_DISABLE_STOPS: assert property (@(posedge i_core_clk) disable iff (i_reset)
        (running && i_guard_disable_command) |=> (!o_enabled && (o_count == ($past(i_service)
            ? $past(reload_q) : $past(o_count) + {15'h0000, $past(tick)}))))
        else $error("disable command did not stop the counter");

    AST_OFF_FROZEN: assert property (@(posedge i_core_clk) disable iff (i_reset)
        (state_q == wdg_pkg::ST_OFF && !i_service) |=> (o_count == $past(o_count)))
        else $error("counter moved while stopped");

    AST_ENABLE_STARTS: assert property (@(posedge i_core_clk) disable iff (i_reset)
        (state_q == wdg_pkg::ST_OFF && i_guard_enable_command && !i_guard_disable_command)
            |=> o_enabled)
        else $error("enable command did not restart the counter");

    AST_PREWARN_THEN_RESET: assert property (@(posedge i_core_clk) disable iff (i_reset)
        o_prewarn_irq |-> (!o_reset_req ##[AST_PW:AST_PW] o_reset_req))
        else $error("reset request not at the expected time after prewarning");

    AST_RESET_NEEDS_WARN: assert property (@(posedge i_core_clk) disable iff (i_reset)
        $rose(o_reset_req) |-> warned_q)
        else $error("reset request without prior prewarning");

    AST_COUNT_STEP: assert property (@(posedge i_core_clk) disable iff (i_reset)
        (running && tick && !i_service) |=> (o_count == $past(o_count) + 16'h0001))
        else $error("counter did not advance by one on a tick");

    AST_TICK_SPACING: assert property (@(posedge i_core_clk) disable iff (i_reset)
        tick |-> (gap_q == (fast_q ? 15'(wdg_pkg::DIV_FAST - 1) : 15'(wdg_pkg::DIV_SLOW - 1))))
        else $error("prescaler tick spacing wrong");

    AST_SERVICE_RELOAD: assert property (@(posedge i_core_clk) disable iff (i_reset)
        (running && i_service) |=> ((o_count == $past(reload_q)) && (gap_q == '0)))
        else $error("service did not reload counter and clear prescaler");

    AST_DEFAULT_INTERVAL: assert property (@(posedge i_core_clk) disable iff (i_reset)
        first_q |-> ((reload_q == 16'hff02) && fast_q))
        else $error("default interval setting wrong");

    AST_OVERFLOW_WRAP: assert property (@(posedge i_core_clk) disable iff (i_reset)
        (overflow && !i_guard_disable_command) |=> (o_prewarn_irq && (o_count == 16'h0000)))
        else $error("wrap from all ones did not raise prewarning");

    COV_SERVICE: cover property (@(posedge i_core_clk) disable iff (i_reset)
        running && i_service);
    COV_DISABLE_ENABLE: cover property (@(posedge i_core_clk) disable iff (i_reset)
        !o_enabled ##1 o_enabled);
    COV_PREWARN: cover property (@(posedge i_core_clk) disable iff (i_reset)
        o_prewarn_irq);
    COV_RESET_REQ: cover property (@(posedge i_core_clk) disable iff (i_reset)
        $rose(o_reset_req));
endmodule

// ### dv/wdg_cpu_model.sv
// Purpose: processor and reset controller seen from the watchdog
// Assumes: requests change on the falling edge, one cycle wide
// Notes:   reset answer waits two cycles so the request can be observed
`timescale 1ns/1ps
module wdg_cpu_model (
    input  wire logic i_core_clk,
    input  wire logic i_reset_req,
    output logic      o_reset,
    output logic      o_service,
    output logic      o_disable,
    output logic      o_enable
);
    initial
    begin
        o_service = 1'b0;
        o_disable = 1'b0;
        o_enable  = 1'b0;
        hold_reset(6);
    end

    task automatic hold_reset(input int n);
        o_reset = 1'b1;
        repeat (n) @(negedge i_core_clk);
        o_reset = 1'b0;
    endtask

    // software must service ahead of overflow
    task automatic service();
        @(negedge i_core_clk) o_service = 1'b1;
        @(negedge i_core_clk) o_service = 1'b0;
    endtask

    task automatic command(input logic dis);
        @(negedge i_core_clk);
        o_disable = dis;
        o_enable  = ~dis;
        @(negedge i_core_clk);
        o_disable = 1'b0;
        o_enable  = 1'b0;
    endtask

    // both commands in one cycle; the disable is expected to win
    task automatic command_both();
        @(negedge i_core_clk);
        o_disable = 1'b1;
        o_enable  = 1'b1;
        @(negedge i_core_clk);
        o_disable = 1'b0;
        o_enable  = 1'b0;
    endtask

    // system reset logic answers the request; hold keeps tests observable
    always @(negedge i_core_clk)
    begin
        if (i_reset_req === 1'b1 && !o_reset)
        begin
            repeat (2) @(negedge i_core_clk);
            hold_reset(6);
        end
    end
endmodule

// ### dv/wdg_timer_test.sv
// Purpose: self-checking bench of the watchdog counter
// Assumes: 10 MHz clock, inputs change on the falling edge
// Notes:   slow divide tested once only, it costs 16384 cycles
`timescale 1ns/1ps
`define CHK(a, b) \
    begin \
        num_checks++; \
        if ((a) !== (b)) \
        begin \
            err_total++; \
            $display("mismatch t=%0t got %h exp %h", $time, a, b); \
        end \
    end
module wdg_timer_test;
    logic        i_core_clk;
    logic        i_reset;
    logic        i_service;
    logic        dis;
    logic        ena;
    logic        i_cfg_load;
    logic [15:0] i_reload_value_setting;
    logic        i_prescale_fast;
    logic        o_enabled;
    logic [15:0] o_count;
    logic        o_prewarn_irq;
    logic        o_reset_req;
    int          err_total;
    int          num_checks;

    wdg_timer dut_u (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_service(i_service),
        .i_guard_disable_command(dis), .i_guard_enable_command(ena),
        .i_cfg_load(i_cfg_load), .i_reload_value_setting(i_reload_value_setting),
        .i_prescale_fast(i_prescale_fast), .o_enabled(o_enabled), .o_count(o_count),
        .o_prewarn_irq(o_prewarn_irq), .o_reset_req(o_reset_req));
    wdg_cpu_model cpu_u (.i_core_clk(i_core_clk), .i_reset_req(o_reset_req),
        .o_reset(i_reset), .o_service(i_service), .o_disable(dis), .o_enable(ena));

    initial
    begin
        i_core_clk = 1'b0;
        forever #50 i_core_clk = ~i_core_clk;
    end

    task automatic report_and_stop();
        if (err_total == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic ready();
        @(negedge i_core_clk);
        while (i_reset !== 1'b0) @(negedge i_core_clk);
    endtask

    task automatic load_config(input logic [15:0] v, input logic fast);
        @(negedge i_core_clk);
        i_reload_value_setting = v;
        i_prescale_fast = fast;
        i_cfg_load = 1'b1;
        @(negedge i_core_clk) i_cfg_load = 1'b0;
    endtask

    // waits for prewarn, returns falling edges passed; bounded
    task automatic to_prewarn(output int n);
        n = 0;
        while (o_prewarn_irq !== 1'b1 && n < 70000)
        begin
            @(negedge i_core_clk);
            n++;
        end
    endtask

    // reset request follows the prewarning after a fixed wait and stands until reset
    task automatic reset_req_seq(input int wait_n);
        repeat (wait_n) @(negedge i_core_clk);
        `CHK(o_reset_req, 1'b0)
        @(negedge i_core_clk);
        `CHK(o_reset_req, 1'b1)
        @(negedge i_core_clk);
        `CHK(o_reset_req, 1'b1)
        // the reset controller answers two cycles late; let it assert before waiting
        repeat (3) @(negedge i_core_clk);
        ready();
    endtask

    task automatic t_default_interval();
        int n;
        `CHK(o_enabled, 1'b1)
        `CHK(o_reset_req, 1'b0)
        to_prewarn(n);
        `CHK(n >= 65000 - 256 && n <= 65000 + 256, 1'b1)
        `CHK(o_count, 16'h0000)
        reset_req_seq(wdg_pkg::PREWARN_CYCLES - 1);
    endtask

    task automatic t_service();
        load_config(16'hfff0, 1'b1);
        cpu_u.service();
        repeat (255) @(negedge i_core_clk);
        `CHK(o_count, 16'hfff0)
        @(negedge i_core_clk);
        `CHK(o_count, 16'hfff1)
    endtask

    task automatic t_disable();
        logic [15:0] held;
        cpu_u.command(1'b1);
        `CHK(o_enabled, 1'b0)
        held = o_count;
        repeat (600) @(negedge i_core_clk);
        `CHK(o_count, held)
        cpu_u.service();
        `CHK(o_count, 16'hfff0)
        cpu_u.command(1'b0);
        `CHK(o_enabled, 1'b1)
        cpu_u.command_both();
        `CHK(o_enabled, 1'b0)
        cpu_u.command(1'b1);
        cpu_u.hold_reset(6);
        ready();
        `CHK(o_enabled, 1'b1)
        `CHK(o_count, wdg_pkg::DEFAULT_RELOAD)
    endtask

    task automatic t_slow();
        int n;
        load_config(16'hffff, 1'b0);
        cpu_u.service();
        to_prewarn(n);
        `CHK(n, 16384)
        @(negedge i_core_clk);
        `CHK(o_prewarn_irq, 1'b0)
        reset_req_seq(wdg_pkg::PREWARN_CYCLES - 2);
    endtask

    initial
    begin
        err_total = 0;
        num_checks = 0;
        i_cfg_load = 1'b0;
        i_reload_value_setting = 16'h0000;
        i_prescale_fast = 1'b1;
        ready();
        t_default_interval();
        t_service();
        t_disable();
        t_slow();
        report_and_stop();
    end

    // longest path is about 82300 cycles
    initial
    begin
        #(100 * 99000);
        err_total++;
        report_and_stop();
    end
endmodule
